// ===== bench/sfpe_engine_props.sv
`timescale 1ns/1ps
`default_nettype none

// pin-level checks on the engine
module sfpe_engine_props #(
  parameter int unsigned ERASE_PROGRAM_CYC = 300,
  parameter int unsigned PROGRAM_ONLY_CYC  = 300,
  parameter int unsigned PAGE_ERASE_CYC    = 300,
  parameter int unsigned BLOCK_ERASE_CYC   = 300,
  parameter int unsigned PAGE_COPY_CYC     = 300
) (
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  // protect and ready pins
  input wire logic wp_n_in,
  input wire logic rdy_busy_out,
  input wire logic rdy_busy_oe_out
);
  // loose ceiling on any busy spell, walk included
  localparam int MAXB = ERASE_PROGRAM_CYC + PAGE_COPY_CYC + BLOCK_ERASE_CYC + 2200;
  int busy_cnt_r;  // length of the current busy spell

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  // counts cycles while busy is shown
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= rdy_busy_oe_out ? busy_cnt_r + 1 : 0;
    end
  end

  // busy held for a while once raised
  sequence s_busy_hold;
    rdy_busy_oe_out [*8];
  endsequence
  // a frame well under way
  sequence s_selected;
    !cs_n_in [*8];
  endsequence

  property p_pin_low;
    rdy_busy_out == 1'b0;
  endproperty
  property p_busy_deselect;
    $rose(rdy_busy_oe_out) |-> $past(cs_n_in, 2);
  endproperty
  property p_busy_min;
    $rose(rdy_busy_oe_out) |-> s_busy_hold;
  endproperty
  property p_busy_max;
    busy_cnt_r <= MAXB;
  endproperty
  property p_oe_off;
    cs_n_in && $past(cs_n_in) |-> !so_oe_out;
  endproperty
  property p_oe_in_frame;
    $rose(so_oe_out) |-> !cs_n_in;
  endproperty
  property p_oe_holds;
    so_oe_out && !cs_n_in ##1 !cs_n_in |-> so_oe_out;
  endproperty
  property p_no_busy_in_frame;
    s_selected |-> !$rose(rdy_busy_oe_out);
  endproperty

  a_pin_low: assert property (p_pin_low) else $error("ready pin data not low");
  a_busy_deselect: assert property (p_busy_deselect) else $error("busy without deselect");
  a_busy_min: assert property (p_busy_min) else $error("busy spell too short");
  a_busy_max: assert property (p_busy_max) else $error("busy spell too long");
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("output enabled outside frame");
  a_oe_holds: assert property (p_oe_holds) else $error("status output dropped");
  a_no_busy_in_frame: assert property (p_no_busy_in_frame) else $error("busy inside frame");
endmodule : sfpe_engine_props

bind sfpe_engine sfpe_engine_props #(
  .ERASE_PROGRAM_CYC(ERASE_PROGRAM_CYC),
  .PROGRAM_ONLY_CYC(PROGRAM_ONLY_CYC),
  .PAGE_ERASE_CYC(PAGE_ERASE_CYC),
  .BLOCK_ERASE_CYC(BLOCK_ERASE_CYC),
  .PAGE_COPY_CYC(PAGE_COPY_CYC)
) i_props (.sys_clk_in, .reset_in, .sck_in, .cs_n_in, .si_in, .so_out, .so_oe_out,
  .wp_n_in, .rdy_busy_out, .rdy_busy_oe_out);

`default_nettype wire

// ===== bench/sfpe_host.sv
`timescale 1ns/1ps
`default_nettype none

// host serial master, clock idles low between frames
module sfpe_host (
  // serial pins toward the engine
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  // quiet pins at start
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // opens a frame, setup before first edge
  task sel;
    cs_n_out = 1'b0;
    #40;
  endtask : sel
  // ends a frame; data line no longer meaningful
  task desel;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #100;
  endtask : desel
  // one byte msb first, in on rise, out read on rise
  task xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      si_out = b[i];
      #6 sck_out = 1'b1;
      r[i] = so_in;
      #6 sck_out = 1'b0;
    end
  endtask : xb
  // opcode then 24 address bits, select held low
  task hdr(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] r;
    sel;
    xb(op, r);
    xb(a[23:16], r);
    xb(a[15:8], r);
    xb(a[7:0], r);
  endtask : hdr
endmodule : sfpe_host

`default_nettype wire

// ===== bench/tb_sfpe_engine.sv
`timescale 1ns/1ps
`default_nettype none

// directed checks of the program and erase engine
module tb_sfpe_engine;
  import sfpe_pkg::*;
  logic sys_clk_in = 1'b0;  // system clock
  logic reset_in = 1'b1;    // reset
  logic wp_n_in = 1'b1;     // write protect
  wire logic sck, cs_n, si, so, so_oe, rb, rb_oe;
  wire logic rb_pin = rb_oe ? rb : 1'b1;  // pulled-up ready pin
  wire logic so_line = so_oe ? so : ~so;  // released output line reads inverted
  int errors = 0;      // mismatches
  int n_compared = 0;  // comparisons
  int k, i;
  logic [7:0] v, r;
  logic [23:0] a;
  // opcodes for buffer one and two
  logic [7:0] op_w [2] = '{8'h84, 8'h87};
  logic [7:0] op_p [2] = '{8'h83, 8'h86};
  logic [7:0] op_n [2] = '{8'h88, 8'h89};
  logic [7:0] op_t [2] = '{8'h82, 8'h85};
  logic [7:0] op_x [2] = '{8'h53, 8'h55};
  logic [7:0] op_c [2] = '{8'h60, 8'h61};
  logic [7:0] op_r [2] = '{8'h58, 8'h59};

  // 100 MHz system clock
  always #5 sys_clk_in = ~sys_clk_in;

  sfpe_engine #(
    .ERASE_PROGRAM_CYC(300),
    .PROGRAM_ONLY_CYC(300),
    .PAGE_ERASE_CYC(300),
    .BLOCK_ERASE_CYC(300),
    .PAGE_COPY_CYC(300)
  ) i_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_out(so), .so_oe_out(so_oe), .wp_n_in(wp_n_in), .rdy_busy_out(rb), .rdy_busy_oe_out(rb_oe)
  );
  sfpe_host i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so_line));

  // compares and counts
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // counts, verdict, end
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // one status byte
  task status(output logic [7:0] s);
    i_host.sel;
    i_host.xb(8'h57, r);
    i_host.xb(8'h00, s);
    i_host.desel;
  endtask : status
  // ends a frame, checks busy, waits for ready
  task fin(input logic eb);
    i_host.desel;
    chk("busy after deselect", {7'h00, !rb_pin}, {7'h00, eb});
    if (eb) begin
      status(v);
      chk("ready bit while busy", {7'h00, v[7]}, 8'h00);
      for (i = 0; i < 5000 && !rb_pin; i++) @(negedge sys_clk_in);
      if (!rb_pin) begin
        errors++;
        close_out;
      end
    end
  endtask : fin
  // command with address only
  task run(input logic [7:0] op, input logic [23:0] ad, input logic eb);
    i_host.hdr(op, ad);
    fin(eb);
  endtask : run
  // command, address, then data bytes
  task wbuf(input logic [7:0] op, input logic [23:0] ad, input int n, input logic [7:0] d0, d1);
    i_host.hdr(op, ad);
    i_host.xb(d0, r);
    for (int j = 1; j < n; j++) i_host.xb(d1, r);
  endtask : wbuf
  // compare then check status
  task comp(input logic [7:0] op, input logic e);
    run(op, a, 1'b1);
    status(v);
    chk("status after compare", {v[7:3], 3'h0}, {1'b1, e, DENSITY_CODE, 3'h0});
  endtask : comp

  // main sequence
  initial begin
    repeat (4) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    status(v);
    chk("status after reset", {v[7:3], 3'h0}, {2'b10, DENSITY_CODE, 3'h0});
    $display("status test done");
    for (k = 0; k < 2; k++) begin
      a = {4'h0, 11'(300 + k), 9'h000};
      run(8'h81, a, 1'b1);
      wbuf(op_w[k], 24'h000107, 264, 8'hFF, 8'hFF);
      fin(1'b0);
      comp(op_c[k], 1'b0);
      wbuf(op_w[k], 24'h000107, 2, 8'hFF, 8'h00);
      fin(1'b0);
      comp(op_c[k], 1'b1);
      run(op_p[k], a, 1'b1);
      comp(op_c[k], 1'b0);
      run(8'h81, a, 1'b1);
      comp(op_c[k], 1'b1);
      run(op_n[k], a, 1'b1);
      comp(op_c[k], 1'b0);
      run(8'h50, {4'h0, 11'd303, 9'h000}, 1'b1); // other page of the same block
      comp(op_c[k], 1'b1);
      run(op_r[k], a, 1'b1);
      comp(op_c[k], 1'b0);
      wbuf(op_t[k], a, 1, 8'h00, 8'h00);
      fin(1'b1);
      comp(op_c[k], 1'b0);
      wbuf(op_w[k], 24'h000000, 1, 8'hFF, 8'hFF);
      fin(1'b0);
      comp(op_c[k], 1'b1);
      run(op_x[k], a, 1'b1);
      comp(op_c[k], 1'b0);
      $display("buffer %0d test done", k + 1);
    end
    @(negedge sys_clk_in) wp_n_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    run(8'h81, {4'h0, 11'd255, 9'h000}, 1'b0);
    run(8'h81, {4'h0, 11'd256, 9'h000}, 1'b1);
    @(negedge sys_clk_in) wp_n_in = 1'b1;
    i_host.sel;
    i_host.xb(8'h81, r);
    i_host.xb(8'h00, r);
    i_host.xb(8'h00, r);
    fin(1'b0);
    $display("protect and partial test done");
    i_host.hdr(8'h81, a);
    i_host.desel;
    i_host.sel;
    i_host.xb(8'hD7, r);
    #2;
    chk("held ready bit busy", {7'h00, so_line}, 8'h00);
    for (i = 0; i < 5000 && so_line !== 1'b1; i++) @(negedge sys_clk_in);
    chk("held ready bit idle", {7'h00, so_line}, 8'h01);
    chk("ready pin idle", {7'h00, rb_pin}, 8'h01);
    i_host.desel;
    $display("halted clock test done");
    close_out;
  end
endmodule : tb_sfpe_engine

`default_nettype wire

// ===== hw/sfpe_engine.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01: status bit seven reads one when idle
// RULE_02: halted clock keeps live ready bit driven
// RULE_03: only eight array operations raise busy
// RULE_04: status bit six holds latest compare result
// RULE_05: status bits five to three fixed density
// RULE_06: buffer write opcodes, ignored bits, start address
// RULE_07: buffer loading wraps until deselect
// RULE_08: program-with-erase opcodes and page address layout
// RULE_09: erase then program page on deselect
// RULE_10: program-only opcodes, page assumed already erased
// RULE_11: page erase sets page to ones
// RULE_12: block erase sets eight pages to ones
// RULE_13: block is upper eight page bits
// RULE_14: program through buffer loads then reprograms
// RULE_15: page copied into buffer on deselect
// RULE_16: compare whole page, then update compare bit
// RULE_17: auto rewrite copies then reprograms page
// RULE_18: host holds select low during command bits
// RULE_19: sample on rising, drive on falling edge
// RULE_20: select frames commands; deselected output floats
// RULE_21: host starts no array operation while busy
// RULE_22: write protect low guards first 256 pages
// RULE_23: msb first; partial commands are dropped
module sfpe_engine #(
  parameter int unsigned ERASE_PROGRAM_CYC = sfpe_pkg::ERASE_PROGRAM_CYC,
  parameter int unsigned PROGRAM_ONLY_CYC  = sfpe_pkg::PROGRAM_ONLY_CYC,
  parameter int unsigned PAGE_ERASE_CYC    = sfpe_pkg::PAGE_ERASE_CYC,
  parameter int unsigned BLOCK_ERASE_CYC   = sfpe_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned PAGE_COPY_CYC     = sfpe_pkg::PAGE_COPY_CYC
) (
  // system clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // serial link
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  output logic      so_out,
  output logic      so_oe_out,
  // write protect
  input  wire logic wp_n_in,
  // open-drain ready/busy pin
  output logic      rdy_busy_out,
  output logic      rdy_busy_oe_out
);
  import sfpe_pkg::*;

  // whole system-domain state
  typedef struct packed {
    logic        cs_s1;     // select sync, first stage
    logic        cs_s2;     // select sync, second stage
    logic        cs_s3;     // select delayed
    logic        cs_s4;     // select delayed again
    logic        tog_s1;    // byte toggle sync, first stage
    logic        tog_s2;    // byte toggle sync, second stage
    logic        tog_s3;    // byte toggle delayed
    logic        wp_s1;     // protect sync, first stage
    logic        wp_s2;     // protect sync, second stage
    logic [2:0]  byte_cnt;  // header bytes taken
    logic [7:0]  opcode;    // received opcode
    logic [23:0] addr;      // received address bits
    logic [8:0]  wr_ptr;    // buffer load pointer
    sfpe_state_e state;     // engine state
    sfpe_kind_e  kind;      // running operation
    logic        buf_sel;   // buffer used
    logic        phase;     // rewrite: copy then program
    logic [10:0] page;      // page being worked
    logic [2:0]  pg_cnt;    // page within block
    logic [8:0]  idx;       // byte within page
    logic        mismatch;  // compare accumulator
    logic        comp;      // latest compare result
    logic        busy;      // array operation running
    logic [23:0] timer;     // cycles since start
    logic [23:0] limit;     // cycles the operation lasts
  } sfpe_sys_s;

  sfpe_sys_s s_r, s_nxt;

  // memories
  logic [7:0] bufm [0:1][0:PAGE_BYTES-1];   // two data buffers
  logic [7:0] arr  [0:ARRAY_BYTES-1];       // main array

  // memory write ports
  logic        hbuf_we;      // host load into a buffer
  logic        hbuf_sel;
  logic [8:0]  hbuf_addr;
  logic [7:0]  hbuf_data;
  logic        ebuf_we;      // engine copy into a buffer
  logic [7:0]  ebuf_data;
  logic        arr_we;       // engine write into the array
  logic [7:0]  arr_data;

  // walk addressing
  logic [10:0] walk_page;
  logic [19:0] arr_addr;
  logic [7:0]  arr_q;
  logic [7:0]  buf_q;

  // link side
  logic [7:0]  link_byte;
  logic        link_tog;
  logic        link_so_bit;
  logic        link_ready_slot;
  logic        link_oe;

  // frame events
  logic        new_byte;
  logic        frame_end;
  logic [10:0] cmd_page;
  logic        cmd_guarded;
  sfpe_kind_e  cmd_kind;

  // kind of array operation behind an opcode
  function automatic sfpe_kind_e kind_of(input logic [7:0] op);
    unique case (op)
      OP_XFER_1, OP_XFER_2:             kind_of = K_XFER;
      OP_CMP_1, OP_CMP_2:               kind_of = K_CMP;
      OP_PGM_ERS_1, OP_PGM_ERS_2,
      OP_THRU_1, OP_THRU_2:             kind_of = K_PGM_ERS;
      OP_PGM_ONLY_1, OP_PGM_ONLY_2:     kind_of = K_PGM_ONLY;
      OP_PAGE_ERASE:                    kind_of = K_PAGE_ERS;
      OP_BLOCK_ERASE:                   kind_of = K_BLOCK_ERS;
      OP_REWRITE_1, OP_REWRITE_2:       kind_of = K_REWRITE;
      default:                          kind_of = K_NONE;
    endcase
  endfunction : kind_of

  // second-buffer opcodes
  function automatic logic second_buf(input logic [7:0] op);
    second_buf = (op == OP_BUF2_WRITE) || (op == OP_PGM_ERS_2) || (op == OP_PGM_ONLY_2) ||
                 (op == OP_THRU_2) || (op == OP_XFER_2) || (op == OP_CMP_2) ||
                 (op == OP_REWRITE_2);
  endfunction : second_buf

  // opcodes followed by buffer data
  function automatic logic loads_buf(input logic [7:0] op);
    loads_buf = (op == OP_BUF1_WRITE) || (op == OP_BUF2_WRITE) ||
                (op == OP_THRU_1) || (op == OP_THRU_2);
  endfunction : loads_buf

  // link front end on the serial clock
  sfpe_link u_link (
    .sck_in         (sck_in),
    .cs_n_in        (cs_n_in),
    .si_in          (si_in),
    .reset_in       (reset_in),
    .comp_in        (s_r.comp),
    .byte_out       (link_byte),
    .byte_tog_out   (link_tog),
    .so_bit_out     (link_so_bit),
    .ready_slot_out (link_ready_slot),
    .so_oe_out      (link_oe)
  );

  // frame events seen in the system domain
  assign new_byte    = s_r.tog_s2 ^ s_r.tog_s3;
  assign frame_end   = s_r.cs_s3 & ~s_r.cs_s4;
  assign cmd_page    = s_r.addr[PAGE_MSB:PAGE_LSB]; // RULE_08
  assign cmd_kind    = kind_of(s_r.opcode);
  // pages below 256 are those with the top three page bits clear
  assign cmd_guarded = ~s_r.wp_s2 && (cmd_page[10:8] == PROTECT_TOP) &&
                       (cmd_kind != K_XFER) && (cmd_kind != K_CMP); // RULE_22

  // array and buffer addressing for the walk
  assign walk_page = (s_r.kind == K_BLOCK_ERS) ? {s_r.page[10:3], s_r.pg_cnt} : s_r.page; // RULE_13
  assign arr_addr  = 20'(walk_page * PAGE_BYTES) + 20'(s_r.idx);
  assign arr_q     = arr[arr_addr];
  assign buf_q     = bufm[s_r.buf_sel][s_r.idx];

  // next state of the engine
  always_comb begin
    s_nxt     = s_r;
    hbuf_we   = 1'b0;
    hbuf_sel  = second_buf(s_r.opcode);
    hbuf_addr = s_r.wr_ptr;
    hbuf_data = link_byte;
    ebuf_we   = 1'b0;
    ebuf_data = arr_q;
    arr_we    = 1'b0;
    arr_data  = ERASED_BYTE;

    // pin and toggle synchronisers
    s_nxt.cs_s1  = cs_n_in;
    s_nxt.cs_s2  = s_r.cs_s1;
    s_nxt.cs_s3  = s_r.cs_s2;
    s_nxt.cs_s4  = s_r.cs_s3;
    s_nxt.tog_s1 = link_tog;
    s_nxt.tog_s2 = s_r.tog_s1;
    s_nxt.tog_s3 = s_r.tog_s2;
    s_nxt.wp_s1  = wp_n_in;
    s_nxt.wp_s2  = s_r.wp_s1;

    // command bytes: opcode, three address bytes, then data
    if (new_byte) begin
      if (s_r.byte_cnt == 3'h0) begin
        s_nxt.opcode   = link_byte;
        s_nxt.byte_cnt = 3'h1;
      end else if (s_r.byte_cnt != HDR_BYTES) begin
        s_nxt.addr     = {s_r.addr[15:0], link_byte}; // RULE_23
        s_nxt.byte_cnt = s_r.byte_cnt + 3'h1;
        s_nxt.wr_ptr   = {s_r.addr[0], link_byte}; // RULE_06
      end else if (loads_buf(s_r.opcode)) begin
        hbuf_we = (s_r.wr_ptr <= LAST_BYTE); // RULE_14
        s_nxt.wr_ptr = (s_r.wr_ptr >= LAST_BYTE) ? 9'h000 : s_r.wr_ptr + 9'h001; // RULE_07
      end
    end else if (s_r.cs_s4) begin
      s_nxt.byte_cnt = 3'h0; // RULE_20
    end

    // start an array operation when a whole command ends
    if (frame_end && (s_r.byte_cnt == HDR_BYTES) && (cmd_kind != K_NONE) &&
        !s_r.busy && !cmd_guarded) begin // RULE_21
      s_nxt.busy     = 1'b1; // RULE_03
      s_nxt.state    = ST_WALK;
      s_nxt.kind     = cmd_kind;
      s_nxt.buf_sel  = second_buf(s_r.opcode);
      s_nxt.page     = cmd_page;
      s_nxt.pg_cnt   = 3'h0;
      s_nxt.idx      = 9'h000;
      s_nxt.phase    = 1'b0;
      s_nxt.mismatch = 1'b0;
      s_nxt.timer    = 24'h000000;
      unique case (cmd_kind)
        K_XFER, K_CMP: s_nxt.limit = 24'(PAGE_COPY_CYC); // RULE_15
        K_PGM_ERS:     s_nxt.limit = 24'(ERASE_PROGRAM_CYC); // RULE_09
        K_PGM_ONLY:    s_nxt.limit = 24'(PROGRAM_ONLY_CYC); // RULE_10
        K_PAGE_ERS:    s_nxt.limit = 24'(PAGE_ERASE_CYC); // RULE_11
        K_BLOCK_ERS:   s_nxt.limit = 24'(BLOCK_ERASE_CYC); // RULE_12
        K_REWRITE:     s_nxt.limit = 24'(PAGE_COPY_CYC + ERASE_PROGRAM_CYC); // RULE_17
        default:       s_nxt.limit = 24'h000001;
      endcase
    end

    // self-timed operation
    unique case (s_r.state)
      ST_IDLE: begin
      end
      ST_WALK: begin
        s_nxt.timer = s_r.timer + 24'h000001;
        unique case (s_r.kind)
          K_XFER: begin
            ebuf_we = 1'b1; // RULE_15
          end
          K_CMP: begin
            s_nxt.mismatch = s_r.mismatch | (arr_q != buf_q); // RULE_16
          end
          K_PGM_ERS: begin
            arr_we   = 1'b1; // RULE_09
            arr_data = buf_q;
          end
          K_PGM_ONLY: begin
            arr_we   = 1'b1; // RULE_10
            arr_data = arr_q & buf_q;
          end
          K_PAGE_ERS, K_BLOCK_ERS: begin
            arr_we   = 1'b1; // RULE_11
          end
          K_REWRITE: begin
            ebuf_we  = ~s_r.phase; // RULE_17
            arr_we   = s_r.phase;
            arr_data = buf_q;
          end
          default: begin
          end
        endcase
        if (s_r.idx == LAST_BYTE) begin
          s_nxt.idx = 9'h000;
          if ((s_r.kind == K_BLOCK_ERS) && (s_r.pg_cnt != LAST_PAGE_IN_BLOCK)) begin
            s_nxt.pg_cnt = s_r.pg_cnt + 3'h1; // RULE_12
          end else if ((s_r.kind == K_REWRITE) && !s_r.phase) begin
            s_nxt.phase = 1'b1;
          end else begin
            s_nxt.state = ST_WAIT;
          end
        end else begin
          s_nxt.idx = s_r.idx + 9'h001;
        end
      end
      ST_WAIT: begin
        s_nxt.timer = s_r.timer + 24'h000001;
        if (s_r.timer >= s_r.limit) begin
          s_nxt.state = ST_IDLE;
          s_nxt.busy  = 1'b0; // RULE_01
          if (s_r.kind == K_CMP) begin
            s_nxt.comp = s_r.mismatch; // RULE_04
          end
        end
      end
    endcase
  end

  // system-domain registers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, cs_s4: 1'b1,
               wp_s1: 1'b1, wp_s2: 1'b1, state: ST_IDLE, kind: K_NONE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // memory writes; host loads and engine copies may hit different buffers at once
  always_ff @(posedge sys_clk_in) begin
    if (hbuf_we) begin
      bufm[hbuf_sel][hbuf_addr] <= hbuf_data;
    end
    if (ebuf_we) begin
      bufm[s_r.buf_sel][s_r.idx] <= ebuf_data;
    end
    if (arr_we) begin
      arr[arr_addr] <= arr_data;
    end
  end

  // serial output: ready slot follows busy live even with the clock stopped
  assign so_out          = link_ready_slot ? ~s_r.busy : link_so_bit; // RULE_02
  assign so_oe_out       = link_oe; // RULE_20
  assign rdy_busy_out    = 1'b0;
  assign rdy_busy_oe_out = s_r.busy;

endmodule : sfpe_engine

`default_nettype wire

// ===== hw/sfpe_link.sv
`timescale 1ns/1ps
`default_nettype none

module sfpe_link (
  // serial pins
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  // reset
  input  wire logic       reset_in,
  // from the system domain
  input  wire logic       comp_in,
  // to the system domain and the output pin
  output logic [7:0]      byte_out,
  output logic            byte_tog_out,
  output logic            so_bit_out,
  output logic            ready_slot_out,
  output logic            so_oe_out
);
  import sfpe_pkg::*;

  // frame state, cleared while deselected
  typedef struct packed {
    logic [6:0] shift;      // bits received so far
    logic [2:0] bit_cnt;    // bit position in the byte
    logic       have_op;    // opcode byte complete
    logic       in_status;  // status read in progress
  } sfpe_rise_s;

  // hand-off state, kept across frames
  typedef struct packed {
    logic [7:0] byte_hold;  // last complete byte
    logic       tog;        // flips once per byte
    logic       comp_s1;    // compare result, first stage
    logic       comp_s2;    // compare result, second stage
  } sfpe_hand_s;

  // output state on the falling edge
  typedef struct packed {
    logic [2:0] idx;        // status bit shown next
    logic       so_bit;     // shown bit
    logic       ready_slot; // ready bit is being shown
    logic       oe;         // pin driven
  } sfpe_fall_s;

  sfpe_rise_s rise_r, rise_nxt;
  sfpe_hand_s hand_r, hand_nxt;
  sfpe_fall_s fall_r, fall_nxt;
  logic       frame_rst;     // deselect or reset
  logic [7:0] full_byte;     // byte completed on this edge
  logic [7:0] status_byte;   // status as seen on the link

  assign frame_rst   = reset_in | cs_n_in; // RULE_20
  assign full_byte   = {rise_r.shift, si_in};
  assign status_byte = {1'b0, hand_r.comp_s2, DENSITY_CODE, ST_LOW_BITS}; // RULE_05

  // input shifting on the rising edge
  always_comb begin
    rise_nxt = rise_r;
    hand_nxt = hand_r;
    hand_nxt.comp_s1 = comp_in;
    hand_nxt.comp_s2 = hand_r.comp_s1;
    rise_nxt.shift   = full_byte[6:0]; // RULE_23
    rise_nxt.bit_cnt = rise_r.bit_cnt + 3'h1; // RULE_19
    if (rise_r.bit_cnt == 3'h7) begin
      hand_nxt.byte_hold = full_byte;
      hand_nxt.tog       = ~hand_r.tog;
      if (!rise_r.have_op) begin
        rise_nxt.have_op   = 1'b1;
        rise_nxt.in_status = (full_byte == OP_STATUS_A) || (full_byte == OP_STATUS_B);
      end
    end
  end

  // frame registers
  always_ff @(posedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      rise_r <= '0;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // hand-off registers
  always_ff @(posedge sck_in or posedge reset_in) begin
    if (reset_in) begin
      hand_r <= '0;
    end else begin
      hand_r <= hand_nxt;
    end
  end

  // status bits driven out on the falling edge, repeating every eight
  always_comb begin
    fall_nxt = fall_r;
    if (rise_r.in_status) begin
      fall_nxt.oe         = 1'b1;
      fall_nxt.so_bit     = status_byte[fall_r.idx];
      fall_nxt.ready_slot = (fall_r.idx == FIRST_STATUS_BIT); // RULE_01
      fall_nxt.idx        = fall_r.idx - 3'h1;
    end
  end

  // output registers
  always_ff @(negedge sck_in or posedge frame_rst) begin
    if (frame_rst) begin
      fall_r <= '{idx: FIRST_STATUS_BIT, default: '0};
    end else begin
      fall_r <= fall_nxt; // RULE_19
    end
  end

  assign byte_out       = hand_r.byte_hold;
  assign byte_tog_out   = hand_r.tog;
  assign so_bit_out     = fall_r.so_bit;
  assign ready_slot_out = fall_r.ready_slot;
  assign so_oe_out      = fall_r.oe;

endmodule : sfpe_link

`default_nettype wire

// ===== hw/sfpe_pkg.sv
package sfpe_pkg;

  // system clock rate
  localparam int unsigned SYS_CLK_MHZ = 100;

  // geometry of the array and the two buffers
  localparam int unsigned PAGE_BYTES   = 264;
  localparam int unsigned PAGE_COUNT   = 2048;
  localparam int unsigned ARRAY_BYTES  = PAGE_BYTES * PAGE_COUNT;
  localparam logic [8:0]  LAST_BYTE    = 9'h107;
  localparam logic [2:0]  LAST_PAGE_IN_BLOCK = 3'h7;
  localparam logic [2:0]  PROTECT_TOP  = 3'h0;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

  // command framing: one opcode byte and three address bytes
  localparam logic [2:0]  HDR_BYTES    = 3'h4;

  // address field positions inside the 24 address bits
  localparam int unsigned PAGE_LSB     = 9;
  localparam int unsigned PAGE_MSB     = 19;

  // status byte layout
  localparam int unsigned ST_READY_BIT = 7;
  localparam int unsigned ST_COMP_BIT  = 6;
  localparam logic [2:0]  ST_LOW_BITS  = 3'h0;
  // density code value is arbitrary
  localparam logic [2:0]  DENSITY_CODE = 3'h5;
  localparam logic [2:0]  FIRST_STATUS_BIT = 3'h7;

  // opcodes
  localparam logic [7:0] OP_STATUS_A   = 8'h57;
  localparam logic [7:0] OP_STATUS_B   = 8'hD7;
  localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_PGM_ERS_1  = 8'h83;
  localparam logic [7:0] OP_PGM_ERS_2  = 8'h86;
  localparam logic [7:0] OP_PGM_ONLY_1 = 8'h88;
  localparam logic [7:0] OP_PGM_ONLY_2 = 8'h89;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE= 8'h50;
  localparam logic [7:0] OP_THRU_1     = 8'h82;
  localparam logic [7:0] OP_THRU_2     = 8'h85;
  localparam logic [7:0] OP_XFER_1     = 8'h53;
  localparam logic [7:0] OP_XFER_2     = 8'h55;
  localparam logic [7:0] OP_CMP_1      = 8'h60;
  localparam logic [7:0] OP_CMP_2      = 8'h61;
  localparam logic [7:0] OP_REWRITE_1  = 8'h58;
  localparam logic [7:0] OP_REWRITE_2  = 8'h59;

  // self-timed operation limits, microseconds
  localparam int unsigned ERASE_PROGRAM_TIME_US = 20000;
  localparam int unsigned PROGRAM_ONLY_TIME_US  = 14000;
  localparam int unsigned PAGE_ERASE_TIME_US    = 8000;
  localparam int unsigned BLOCK_ERASE_TIME_US   = 12000;
  localparam int unsigned PAGE_COPY_TIME_US     = 300;

  // the same limits as system clock cycles (exact whole multiples, nothing rounds)
  localparam int unsigned ERASE_PROGRAM_CYC = ERASE_PROGRAM_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned PROGRAM_ONLY_CYC  = PROGRAM_ONLY_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned PAGE_ERASE_CYC    = PAGE_ERASE_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned BLOCK_ERASE_CYC   = BLOCK_ERASE_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned PAGE_COPY_CYC     = PAGE_COPY_TIME_US * SYS_CLK_MHZ;

  // kinds of array operation
  typedef enum logic [2:0] {
    K_NONE, K_XFER, K_CMP, K_PGM_ERS, K_PGM_ONLY, K_PAGE_ERS, K_BLOCK_ERS, K_REWRITE
  } sfpe_kind_e;

  // engine states
  typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_WAIT} sfpe_state_e;

endpackage : sfpe_pkg
